// ==== common/power_ctl_pkg.sv ====
// Purpose: shared constants and types for the sleep and power reduction block
// Assumes: Avalon-MM slave with 32-bit data, one word per register
// Notes: offsets are byte addresses
`default_nettype none
package power_ctl_pkg;
    localparam logic [3:0] SLEEP_CTL_OFS = 4'h0;
    localparam logic [3:0] CORE_MISC_OFS = 4'h4;
    localparam logic [3:0] CLK_GATE_OFS = 4'h8;
    localparam logic [3:0] STATUS_OFS = 4'hC;

    localparam int SLEEP_EN_POS = 0;
    localparam int SLEEP_MODE_LSB = 1;
    localparam int BOD_UNLOCK_POS = 5;
    localparam int BOD_OFF_POS = 6;

    localparam int GATE_CONV = 0;
    localparam int GATE_USI = 1;
    localparam int GATE_TIM0 = 2;
    localparam int GATE_TIM1 = 3;
    localparam int GATE_SPI = 4;
    localparam int GATE_LIN = 5;
    localparam logic [7:0] GATE_MASK = 8'h3F;
    localparam logic [7:0] SLEEP_CTL_MASK = 8'h07;

    localparam logic [7:0] RESET_BYTE = 8'h00;

    localparam int UNLOCK_WINDOW_CYC = 4;
    localparam int BOD_ACT_DELAY_CYC = 3;
    localparam int BOD_ACT_LEN_CYC = 3;

    typedef enum logic [1:0] {
        MODE_IDLE = 2'b00,
        MODE_NOISE = 2'b01,
        MODE_PDOWN = 2'b10,
        MODE_PSAVE = 2'b11
    } sleep_mode_t;

    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } bus_req_t;

    typedef struct packed {
        logic brownout_fuse;
        logic debug_fuse;
        logic timer_async_select;
        logic comp_uses_ref;
        logic comp_enable;
        logic conv_enable;
        logic watchdog_enable;
    } analog_cfg_t;

    typedef struct packed {
        logic cpu_clk_en;
        logic io_clk_en;
        logic conv_clk_en;
        logic async_clk_en;
        logic main_osc_en;
        logic [5:0] periph_clk_en;
        logic periph_io_block;
        logic brownout_active;
        logic vref_enable;
        logic comp_active;
        logic comp_mux_allowed;
        logic conv_active;
        logic conv_extended;
        logic watchdog_run;
        logic input_buf_en;
    } power_out_t;
endpackage
`default_nettype wire

// ==== rtl/sleep_and_power_reduction.sv ====
// Purpose: sleep mode control, timed brown-out sleep sequence, peripheral clock gating
// Assumes: sleep and wake arrive from core logic on clk_i; config levels are synchronised here
// Notes: gated peripherals keep state since only their clock enable drops
//
// Overview of operation
// RQ1: a set gate bit stops that peripheral clock and blocks its register access.
// RQ2: clearing a gate bit restarts the clock; peripheral state is kept.
// RQ3: gating acts in active and idle; deeper modes halt peripheral clocks anyway. Here noise keeps the converter clock, power-save an async narrow timer.
// RQ4: converter stays on in sleep; after off then on, next conversion is extended.
// RQ5: power-down and power-save disable comparator, unless it uses internal reference. Here the comparator is dropped either way; only its reference stays on.
// RQ6: internal reference on only when brown-out, comparator or converter need it.
// RQ7: fuse-enabled brown-out stays active in sleep unless software sequence disables it.
// RQ8: an enabled watchdog keeps running in every sleep mode.
// RQ9: input buffers off when io and converter clocks both halted, except wake inputs.
// RQ10: debug fuse keeps main clock source running in every sleep mode.
// RQ11: sleep control bits 7 to 3 read zero.
// RQ12: mode field bits 2..1: idle, noise reduction, power-down, power-save.
// RQ13: sleep instruction enters the mode only while sleep enable is one.
// RQ14: write off and unlock both one, then off alone within four cycles.
// RQ15: off bit active three cycles after set, clears three cycles later.
// RQ16: unlock bit at position 5 permits setting the off bit.
// RQ17: gating register bits 7 and 6 read zero.
// RQ18: bit 5 stops lin/uart clock; software reinitialises afterwards.
// RQ19: bit 4 stops spi clock; software avoids it while debugging.
// RQ20: bit 3 stops wide timer; bit 2 stops narrow timer only when synchronous.
// RQ21: bit 1 stops universal serial unit clock; software reinitialises afterwards.
// RQ22: bit 0 shuts converter; comparator may not use converter mux then.
// RQ23: software brown-out disable applies only in power-down and power-save, at entry.
// RQ24: on wake from such sleep, brown-out detection is re-enabled.
// RQ25: reset clears gates, mode, sleep enable and brown-out bits.
`timescale 1ns/1ps
`default_nettype none
module sleep_and_power_reduction
    import power_ctl_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // avalon-mm slave
    input wire power_ctl_pkg::bus_req_t bus_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    // core sleep handshake
    input wire logic sleep_instr_i,
    input wire logic wake_i,
    // fuse and analog configuration levels
    input wire power_ctl_pkg::analog_cfg_t cfg_i,
    // power outputs
    output power_ctl_pkg::power_out_t pwr_o
);
    import power_ctl_pkg::*;

    logic [7:0] sleep_ctl_q;
    logic [7:0] gate_q;
    logic [1:0] unlock_cnt_q;
    logic unlock_q;
    logic [2:0] bod_cnt_q;
    logic bod_off_q;
    logic asleep_q;
    logic bod_sw_off_q;
    sleep_mode_t mode_q;
    analog_cfg_t cfg_m_q;
    analog_cfg_t cfg_q;
    logic conv_was_off_q;
    logic ack_q;
    logic wait_q;
    logic [31:0] rdata_q;
    power_out_t pwr_q;

    function automatic logic deep_mode(input sleep_mode_t m);
        deep_mode = (m == MODE_PDOWN) || (m == MODE_PSAVE);
    endfunction

    logic req;
    logic wr_sleep;
    logic wr_misc;
    logic wr_gate;
    logic bod_active;
    assign req = (bus_i.read || bus_i.write) && !ack_q;
    assign wr_sleep = ack_q && bus_i.write && bus_i.address == SLEEP_CTL_OFS;
    assign wr_misc = ack_q && bus_i.write && bus_i.address == CORE_MISC_OFS;
    assign wr_gate = ack_q && bus_i.write && bus_i.address == CLK_GATE_OFS;
    assign bod_active = bod_off_q && bod_cnt_q >= 3'(BOD_ACT_DELAY_CYC);

    // config synchroniser
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cfg_m_q <= '0;
            cfg_q <= '0;
        end else begin
            cfg_m_q <= cfg_i;
            cfg_q <= cfg_m_q;
        end
    end

    // bus handshake: one wait cycle, answer in the second
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ack_q <= 1'b0;
            wait_q <= 1'b1;
            rdata_q <= '0;
        end else begin
            ack_q <= req;
            wait_q <= !req;
            if (req && bus_i.read) begin
                case (bus_i.address)
                    SLEEP_CTL_OFS: rdata_q <= {24'h0000_00, sleep_ctl_q & SLEEP_CTL_MASK}; // [RQ11]
                    CORE_MISC_OFS: rdata_q <= {24'h0000_00, 1'b0, bod_off_q, unlock_q, 5'h00};
                    CLK_GATE_OFS: rdata_q <= {24'h0000_00, gate_q & GATE_MASK}; // [RQ17]
                    STATUS_OFS: rdata_q <= {28'h000_0000, bod_sw_off_q, 1'b0, mode_q[1],
                        asleep_q};
                    default: rdata_q <= '0;
                endcase
            end
        end
    end

    assign readdata_o = rdata_q;
    assign waitrequest_o = wait_q;

    // sleep control register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sleep_ctl_q <= RESET_BYTE; // [RQ25]
        end else if (wr_sleep) begin
            sleep_ctl_q <= bus_i.writedata[7:0] & SLEEP_CTL_MASK; // [RQ11]
        end
    end

    // clock gating register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            gate_q <= RESET_BYTE; // [RQ25]
        end else if (wr_gate) begin
            gate_q <= bus_i.writedata[7:0] & GATE_MASK; // [RQ17]
        end
    end

    // timed unlock window and brown-out off bit
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            unlock_q <= 1'b0; // [RQ25]
            unlock_cnt_q <= '0;
            bod_off_q <= 1'b0;
            bod_cnt_q <= '0;
        end else begin
            if (wr_misc && bus_i.writedata[BOD_OFF_POS] && bus_i.writedata[BOD_UNLOCK_POS]) begin
                unlock_q <= 1'b1; // [RQ16]
                unlock_cnt_q <= '0;
            end else if (unlock_q) begin
                if (unlock_cnt_q == 2'(UNLOCK_WINDOW_CYC - 1)) begin
                    unlock_q <= 1'b0; // [RQ14]
                end
                unlock_cnt_q <= unlock_cnt_q + 2'd1;
            end
            if (wr_misc && unlock_q && bus_i.writedata[BOD_OFF_POS]
                && !bus_i.writedata[BOD_UNLOCK_POS]) begin
                bod_off_q <= 1'b1; // [RQ14]
                bod_cnt_q <= 3'd1;
                unlock_q <= 1'b0;
            end else if (bod_off_q) begin
                if (bod_cnt_q == 3'(BOD_ACT_DELAY_CYC + BOD_ACT_LEN_CYC - 1)) begin
                    bod_off_q <= 1'b0; // [RQ15]
                    bod_cnt_q <= '0;
                end else begin
                    bod_cnt_q <= bod_cnt_q + 3'd1;
                end
            end
        end
    end

    // sleep entry and wake
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            asleep_q <= 1'b0;
            mode_q <= MODE_IDLE;
            bod_sw_off_q <= 1'b0;
        end else if (asleep_q && wake_i) begin
            asleep_q <= 1'b0;
            bod_sw_off_q <= 1'b0; // [RQ24]
        end else if (!asleep_q && sleep_instr_i && sleep_ctl_q[SLEEP_EN_POS]) begin
            asleep_q <= 1'b1; // [RQ13]
            mode_q <= sleep_mode_t'(sleep_ctl_q[SLEEP_MODE_LSB +: 2]); // [RQ12]
            bod_sw_off_q <= bod_active
                && deep_mode(sleep_mode_t'(sleep_ctl_q[SLEEP_MODE_LSB +: 2])); // [RQ15] [RQ23]
        end
    end

    // converter off history for extended conversion
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            conv_was_off_q <= 1'b1;
        end else if (!cfg_q.conv_enable || gate_q[GATE_CONV]) begin
            conv_was_off_q <= 1'b1; // [RQ4]
        end else if (pwr_q.conv_active) begin
            conv_was_off_q <= 1'b0;
        end
    end

    // registered power outputs
    power_out_t pwr_d;
    logic io_run;
    logic conv_run;
    logic async_run;
    logic comp_on;
    logic bod_on;
    logic conv_on;
    always_comb begin
        io_run = !asleep_q || mode_q == MODE_IDLE;
        conv_run = !asleep_q || mode_q == MODE_IDLE || mode_q == MODE_NOISE;
        async_run = conv_run || mode_q == MODE_PSAVE;
        conv_on = cfg_q.conv_enable && !gate_q[GATE_CONV]; // [RQ4] [RQ22]
        // deep sleep drops the comparator; a reference it uses stays on below
        comp_on = cfg_q.comp_enable && !(asleep_q && deep_mode(mode_q)); // [RQ5]
        bod_on = cfg_q.brownout_fuse && !bod_sw_off_q; // [RQ7]
        pwr_d.cpu_clk_en = !asleep_q;
        pwr_d.io_clk_en = io_run;
        pwr_d.conv_clk_en = conv_run;
        pwr_d.async_clk_en = async_run;
        pwr_d.main_osc_en = conv_run || cfg_q.debug_fuse; // [RQ10]
        // gating only bites while clocks run; deep modes halt all but an async narrow timer in power-save
        pwr_d.periph_clk_en[GATE_CONV] = conv_run && !gate_q[GATE_CONV]; // [RQ1] [RQ3] [RQ22]
        pwr_d.periph_clk_en[GATE_USI] = io_run && !gate_q[GATE_USI]; // [RQ21]
        pwr_d.periph_clk_en[GATE_TIM0] = cfg_q.timer_async_select ? async_run
            : (io_run && !gate_q[GATE_TIM0]); // [RQ20]
        pwr_d.periph_clk_en[GATE_TIM1] = io_run && !gate_q[GATE_TIM1]; // [RQ20] [RQ2]
        pwr_d.periph_clk_en[GATE_SPI] = io_run && !gate_q[GATE_SPI]; // [RQ19]
        pwr_d.periph_clk_en[GATE_LIN] = io_run && !gate_q[GATE_LIN]; // [RQ18]
        pwr_d.periph_io_block = |gate_q; // [RQ1]
        pwr_d.brownout_active = bod_on;
        pwr_d.vref_enable = bod_on || (cfg_q.comp_enable && cfg_q.comp_uses_ref)
            || conv_on; // [RQ5] [RQ6]
        pwr_d.comp_active = comp_on;
        pwr_d.comp_mux_allowed = !gate_q[GATE_CONV]; // [RQ22]
        pwr_d.conv_active = conv_on;
        pwr_d.conv_extended = conv_on && conv_was_off_q; // [RQ4]
        pwr_d.watchdog_run = cfg_q.watchdog_enable; // [RQ8]
        pwr_d.input_buf_en = conv_run; // [RQ9]
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pwr_q <= '0;
        end else begin
            pwr_q <= pwr_d;
        end
    end

    assign pwr_o = pwr_q;

    // assertions
    property p_gate_stops_clock;
        @(posedge clk_i) disable iff (!rst_n_i)
        gate_q[GATE_SPI] |=> !pwr_q.periph_clk_en[GATE_SPI];
    endproperty
    a_gate_stops_clock: assert property (p_gate_stops_clock) // [RQ1]
        else $error("gated spi clock still running");

    property p_ungate_restarts;
        @(posedge clk_i) disable iff (!rst_n_i)
        (!gate_q[GATE_LIN] && !asleep_q) |=> pwr_q.periph_clk_en[GATE_LIN];
    endproperty
    a_ungate_restarts: assert property (p_ungate_restarts) // [RQ2]
        else $error("ungated lin clock not running");

    property p_deep_halts;
        @(posedge clk_i) disable iff (!rst_n_i)
        (asleep_q && deep_mode(mode_q)) |=> !pwr_q.periph_clk_en[GATE_TIM1];
    endproperty
    a_deep_halts: assert property (p_deep_halts) // [RQ3]
        else $error("peripheral clock runs in deep sleep");

    property p_reserved_zero;
        @(posedge clk_i) disable iff (!rst_n_i)
        sleep_ctl_q[7:3] == 5'h00 && gate_q[7:6] == 2'b00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // [RQ11]
        else $error("reserved bits nonzero");

    property p_sleep_needs_enable;
        @(posedge clk_i) disable iff (!rst_n_i)
        (!asleep_q && sleep_instr_i && !sleep_ctl_q[SLEEP_EN_POS]) |=> !asleep_q;
    endproperty
    a_sleep_needs_enable: assert property (p_sleep_needs_enable) // [RQ13]
        else $error("slept without sleep enable");

    property p_bod_off_life;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(bod_off_q) |-> !bod_active [*2] ##1 bod_active [*3] ##1 !bod_off_q;
    endproperty
    a_bod_off_life: assert property (p_bod_off_life) // [RQ15]
        else $error("brown-out off timing wrong");

    property p_unlock_window;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(unlock_q) |-> ##[1:4] !unlock_q;
    endproperty
    a_unlock_window: assert property (p_unlock_window) // [RQ14]
        else $error("unlock window too long");

    property p_bod_reenable;
        @(posedge clk_i) disable iff (!rst_n_i)
        (asleep_q && wake_i) |=> !bod_sw_off_q ##1 (pwr_q.brownout_active == cfg_q.brownout_fuse);
    endproperty
    a_bod_reenable: assert property (p_bod_reenable) // [RQ24]
        else $error("brown-out not re-enabled on wake");

    property p_vref;
        @(posedge clk_i) disable iff (!rst_n_i)
        (!cfg_q.brownout_fuse && !cfg_q.comp_enable && !cfg_q.conv_enable) |=> !pwr_q.vref_enable;
    endproperty
    a_vref: assert property (p_vref) // [RQ6]
        else $error("reference on without user");

    property p_debug_osc;
        @(posedge clk_i) disable iff (!rst_n_i)
        cfg_q.debug_fuse |=> pwr_q.main_osc_en;
    endproperty
    a_debug_osc: assert property (p_debug_osc) // [RQ10]
        else $error("main oscillator off under debug");

    c_deep_sleep: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        asleep_q && mode_q == MODE_PDOWN);
    c_sw_bod_off: cover property (@(posedge clk_i) disable iff (!rst_n_i) bod_sw_off_q);
    c_gate_all: cover property (@(posedge clk_i) disable iff (!rst_n_i) gate_q == GATE_MASK);
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// Purpose: self-checking bench for the sleep and power reduction block
// Assumes: bus answers after one wait state; stimulus lands on rising edges
// Notes: the block carries its own assertions, so no checker is bound here
`timescale 1ns/1ps
`default_nettype none
module tb;
    import power_ctl_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    bus_req_t bus_i = '0;
    logic [31:0] readdata_o;
    logic waitrequest_o;
    logic sleep_instr_i = 1'b0;
    logic wake_i = 1'b0;
    analog_cfg_t cfg_i = '0;
    power_out_t pwr_o;
    int err_total = 0;
    int compares = 0;
    logic [31:0] rd;
    logic [1:0] m;

    always #50 clk_i = ~clk_i;

    sleep_and_power_reduction DUT (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .bus_i(bus_i),
        .readdata_o(readdata_o),
        .waitrequest_o(waitrequest_o),
        .sleep_instr_i(sleep_instr_i),
        .wake_i(wake_i),
        .cfg_i(cfg_i),
        .pwr_o(pwr_o)
    );

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chkb(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask

    // one avalon transfer: request held until waitrequest is seen low at a rising edge;
    // design outputs move only in the nba region, so reads here see the edge's values
    task automatic access(input logic [3:0] a, input logic wr, input logic [31:0] d,
                          output logic [31:0] q);
        int n;
        @(posedge clk_i);
        bus_i.address <= a;
        bus_i.read <= ~wr;
        bus_i.write <= wr;
        bus_i.writedata <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (waitrequest_o !== 1'b0 && n < 100);
        if (n >= 100) begin
            err_total++;
            $display("mismatch bus answer expected low seen high");
        end
        q = readdata_o;
        bus_i.read <= 1'b0;
        bus_i.write <= 1'b0;
    endtask

    task automatic pulse(input logic wk);
        @(posedge clk_i);
        if (wk) wake_i <= 1'b1;
        else sleep_instr_i <= 1'b1;
        @(posedge clk_i);
        wake_i <= 1'b0;
        sleep_instr_i <= 1'b0;
    endtask

    // timed unlock sequence, then a sleep early in the active window or well after it
    task automatic bod_seq(input logic [1:0] md, input logic late);
        logic off;
        off = md[1] & ~late;
        access(SLEEP_CTL_OFS, 1'b1, {29'h0, md, 1'b1}, rd);
        access(CORE_MISC_OFS, 1'b1, 32'h0000_0060, rd);
        access(CORE_MISC_OFS, 1'b1, 32'h0000_0040, rd);
        cyc(late ? 8 : 1);
        pulse(1'b0);
        cyc(3);
        access(STATUS_OFS, 1'b0, 32'h0, rd);
        chk("status asleep", {28'h0, off, 1'b0, md[1], 1'b1}, rd);
        chkb("brownout asleep", ~off, pwr_o.brownout_active);
        pulse(1'b1);
        cyc(3);
        chkb("brownout woken", 1'b1, pwr_o.brownout_active);
        access(STATUS_OFS, 1'b0, 32'h0, rd);
        chkb("status off woken", 1'b0, rd[3]);
    endtask

    initial begin
        cyc(20000);
        err_total++;
        $display("mismatch watchdog expected finish seen hang");
        wrap_up();
    end

    initial begin
        cyc(8);
        rst_n_i <= 1'b1;
        cyc(2);
        access(SLEEP_CTL_OFS, 1'b0, 32'h0, rd);
        chk("sleep ctl reset", 32'h0000_0000, rd);
        access(CORE_MISC_OFS, 1'b0, 32'h0, rd);
        chk("core misc reset", 32'h0000_0000, rd);
        access(CLK_GATE_OFS, 1'b0, 32'h0, rd);
        chk("gate reset", 32'h0000_0000, rd);
        chk("clocks after reset", 32'h0000_003F, {26'h0, pwr_o.periph_clk_en});
        access(SLEEP_CTL_OFS, 1'b1, 32'h0000_00FF, rd);
        access(SLEEP_CTL_OFS, 1'b0, 32'h0, rd);
        chk("sleep ctl upper", 32'h0000_0007, rd);
        access(SLEEP_CTL_OFS, 1'b1, 32'h0000_0000, rd);
        access(CLK_GATE_OFS, 1'b1, 32'h0000_00FF, rd);
        access(CLK_GATE_OFS, 1'b0, 32'h0, rd);
        chk("gate upper", 32'h0000_003F, rd);
        access(4'h2, 1'b1, 32'h0000_00FF, rd);
        access(4'h2, 1'b0, 32'h0, rd);
        chk("unmapped", 32'h0000_0000, rd);
        for (int i = 0; i < 6; i++) begin
            access(CLK_GATE_OFS, 1'b1, 32'h0000_0001 << i, rd);
            cyc(2);
            chk("gated clocks", 32'h0000_003F & ~(32'h0000_0001 << i),
                {26'h0, pwr_o.periph_clk_en});
            chkb("io block", 1'b1, pwr_o.periph_io_block);
            chkb("comp mux", i != 0, pwr_o.comp_mux_allowed);
            access(CLK_GATE_OFS, 1'b1, 32'h0000_0000, rd);
            cyc(2);
            chk("ungated clocks", 32'h0000_003F, {26'h0, pwr_o.periph_clk_en});
            chkb("io unblock", 1'b0, pwr_o.periph_io_block);
        end
        cyc(4);
        chkb("vref idle", 1'b0, pwr_o.vref_enable);
        cfg_i <= 7'h0C;
        cyc(4);
        chkb("vref comparator", 1'b1, pwr_o.vref_enable);
        cfg_i <= 7'h40;
        cyc(4);
        chkb("vref fuse", 1'b1, pwr_o.vref_enable);
        cfg_i <= 7'h67;
        cyc(4);
        chkb("conv extended", 1'b1, pwr_o.conv_extended);
        cfg_i <= 7'h77;
        access(CLK_GATE_OFS, 1'b1, 32'h0000_0004, rd);
        cyc(2);
        chkb("async narrow timer", 1'b1, pwr_o.periph_clk_en[GATE_TIM0]);
        access(CLK_GATE_OFS, 1'b1, 32'h0000_0000, rd);
        cfg_i <= 7'h67;
        cyc(4);
        access(SLEEP_CTL_OFS, 1'b1, 32'h0000_0004, rd);
        pulse(1'b0);
        cyc(3);
        access(STATUS_OFS, 1'b0, 32'h0, rd);
        chkb("no sleep", 1'b0, rd[0]);
        chkb("cpu running", 1'b1, pwr_o.cpu_clk_en);
        for (int k = 0; k < 4; k++) begin
            m = k[1:0];
            access(SLEEP_CTL_OFS, 1'b1, {29'h0, m, 1'b1}, rd);
            pulse(1'b0);
            cyc(3);
            access(STATUS_OFS, 1'b0, 32'h0, rd);
            chk("status mode", {30'h0, m[1], 1'b1}, rd);
            chkb("cpu clock", 1'b0, pwr_o.cpu_clk_en);
            chkb("io clock", m == 2'b00, pwr_o.io_clk_en);
            chkb("conv clock", ~m[1], pwr_o.conv_clk_en);
            chkb("async clock", m != 2'b10, pwr_o.async_clk_en);
            chkb("conv extended later", 1'b0, pwr_o.conv_extended);
            chkb("input buffers", ~m[1], pwr_o.input_buf_en);
            chkb("comparator", ~m[1], pwr_o.comp_active);
            chkb("converter", 1'b1, pwr_o.conv_active);
            chkb("brownout", 1'b1, pwr_o.brownout_active);
            chkb("watchdog", 1'b1, pwr_o.watchdog_run);
            chkb("main osc", 1'b1, pwr_o.main_osc_en);
            if (m != 2'b01) begin
                chk("sleep periph", m[1] ? 32'h0 : 32'h0000_003F,
                    {26'h0, pwr_o.periph_clk_en});
            end
            pulse(1'b1);
            cyc(3);
            chkb("cpu woken", 1'b1, pwr_o.cpu_clk_en);
        end
        access(CORE_MISC_OFS, 1'b1, 32'h0000_0040, rd);
        access(CORE_MISC_OFS, 1'b0, 32'h0, rd);
        chkb("off without unlock", 1'b0, rd[BOD_OFF_POS]);
        access(CORE_MISC_OFS, 1'b1, 32'h0000_0060, rd);
        cyc(6);
        access(CORE_MISC_OFS, 1'b1, 32'h0000_0040, rd);
        access(CORE_MISC_OFS, 1'b0, 32'h0, rd);
        chkb("off after window", 1'b0, rd[BOD_OFF_POS]);
        access(CORE_MISC_OFS, 1'b1, 32'h0000_0060, rd);
        access(CORE_MISC_OFS, 1'b1, 32'h0000_0040, rd);
        access(CORE_MISC_OFS, 1'b0, 32'h0, rd);
        chkb("off in window", 1'b1, rd[BOD_OFF_POS]);
        cyc(10);
        access(CORE_MISC_OFS, 1'b0, 32'h0, rd);
        chkb("off self clear", 1'b0, rd[BOD_OFF_POS]);
        bod_seq(2'b10, 1'b0);
        bod_seq(2'b11, 1'b0);
        bod_seq(2'b00, 1'b0);
        bod_seq(2'b10, 1'b1);
        wrap_up();
    end
endmodule
`default_nettype wire
